// ---- verilog/spp_port.sv ----
// Purpose: byte-wide serial peripheral port, master or slave, mode 0 framing
// Assumes: pin inputs synchronous to clk_in; control bits arrive as plain inputs
// Notes: received bytes pass a two-entry buffer; a read pops it
`timescale 1ns/1ns
module spp_port (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire spp_pkg::spp_sfr_req_t sfr_req_in,
  output logic [7:0] sfr_rdata_out,
  input wire logic enable_in,
  input wire logic master_in,
  input wire logic [1:0] select_mode_field_in,
  input wire logic clear_flags_in,
  input wire spp_pkg::spp_pins_t pin_in,
  output spp_pkg::spp_pins_t pin_out,
  output spp_pkg::spp_pins_t pin_oe_out,
  output logic select_pin_mapped_out,
  output logic busy_out,
  output logic rx_valid_out,
  output logic mode_fault_out,
  output logic overrun_out
);
  logic [7:0] divider_reg, divider_next;
  logic [7:0] tx_reg, tx_next;
  logic [7:0] shift_reg, shift_next;
  logic [7:0] cnt_reg, cnt_next;
  logic [3:0] bits_reg, bits_next;
  logic sck_reg, sck_next;
  logic sck_prev_reg, sck_prev_next;
  logic nss_prev_reg, nss_prev_next;
  logic fault_reg, fault_next;
  logic ovr_reg, ovr_next;
  logic [7:0] rdata_reg, rdata_next;
  spp_pkg::spp_state_t state_reg, state_next;
  logic master_fn, selected, sck_rise, nss_fall;
  logic wr_data, rd_data, done, push, push_ready;
  logic [7:0] done_byte;
  logic [7:0] fifo_mem_reg [spp_pkg::FIFO_DEPTH];
  logic [7:0] fifo_mem_next [spp_pkg::FIFO_DEPTH];
  logic wptr_reg, wptr_next, rptr_reg, rptr_next;
  logic [1:0] count_reg, count_next;
  logic pop;

  function automatic logic is_addr(input spp_pkg::spp_sfr_req_t r, input logic [7:0] a);
    is_addr = r.addr == a;
  endfunction

  assign wr_data = sfr_req_in.wr && is_addr(sfr_req_in, spp_pkg::ADDR_TX_RX_DATA);
  assign rd_data = sfr_req_in.rd && is_addr(sfr_req_in, spp_pkg::ADDR_TX_RX_DATA);
  assign master_fn = enable_in && master_in && !fault_reg;
  // three-wire slave is always selected, mode 01 slave by a low select input
  assign selected = (select_mode_field_in == spp_pkg::SEL_THREE_WIRE) ||
    ((select_mode_field_in == spp_pkg::SEL_FOUR_SLAVE) && !pin_in.slave_select_line);
  assign sck_rise = pin_in.sck && !sck_prev_reg;
  assign nss_fall = nss_prev_reg && !pin_in.slave_select_line;
  assign push_ready = count_reg != spp_pkg::FIFO_FULL_CNT;

  // shift engine and control
  always_comb begin
    divider_next = divider_reg;
    tx_next = tx_reg;
    shift_next = shift_reg;
    cnt_next = cnt_reg;
    bits_next = bits_reg;
    sck_next = sck_reg;
    state_next = state_reg;
    fault_next = fault_reg;
    ovr_next = ovr_reg;
    done = 1'b0;
    done_byte = shift_reg;
    sck_prev_next = pin_in.sck;
    nss_prev_next = pin_in.slave_select_line;
    rdata_next = rdata_reg;
    if (sfr_req_in.wr && is_addr(sfr_req_in, spp_pkg::ADDR_SCK_DIVIDER)) begin
      divider_next = sfr_req_in.wdata;
    end
    if (wr_data) begin
      tx_next = sfr_req_in.wdata;
    end
    if (sfr_req_in.rd) begin
      if (is_addr(sfr_req_in, spp_pkg::ADDR_SCK_DIVIDER)) begin
        rdata_next = divider_reg;
      end else if (rd_data && rx_valid_out) begin
        rdata_next = fifo_mem_reg[rptr_reg];
      end else begin
        rdata_next = spp_pkg::RDATA_EMPTY;
      end
    end
    if (clear_flags_in) begin
      fault_next = 1'b0;
      ovr_next = 1'b0;
    end
    if (enable_in && master_in && nss_fall &&
        select_mode_field_in == spp_pkg::SEL_FOUR_SLAVE) begin
      fault_next = 1'b1;
    end
    if (!enable_in) begin
      state_next = spp_pkg::SPP_IDLE;
      sck_next = 1'b0;
      bits_next = 4'h0;
    end else if (master_fn) begin
      case (state_reg)
        spp_pkg::SPP_IDLE: begin
          sck_next = 1'b0;
          if (wr_data && push_ready) begin
            shift_next = sfr_req_in.wdata;
            cnt_next = divider_reg;
            bits_next = 4'h0;
            state_next = spp_pkg::SPP_SHIFT;
          end
        end
        spp_pkg::SPP_SHIFT: begin
          if (cnt_reg == 8'h00) begin
            cnt_next = divider_reg;
            sck_next = !sck_reg;
            if (!sck_reg) begin
              shift_next = {shift_reg[6:0], pin_in.miso};
              bits_next = bits_reg + 4'h1;
            end else if (bits_reg == spp_pkg::BITS_PER_XFER) begin
              done = 1'b1;
              state_next = spp_pkg::SPP_IDLE;
            end
          end else begin
            cnt_next = cnt_reg - 8'h01;
          end
        end
        default: state_next = spp_pkg::SPP_IDLE;
      endcase
    end else begin
      state_next = spp_pkg::SPP_IDLE;
      sck_next = 1'b0;
      if (!selected) begin
        bits_next = 4'h0;
        shift_next = tx_reg;
      end else if (sck_rise) begin
        shift_next = {shift_reg[6:0], pin_in.mosi};
        bits_next = bits_reg + 4'h1;
        if (bits_reg == spp_pkg::BITS_LAST) begin
          done = 1'b1;
          done_byte = {shift_reg[6:0], pin_in.mosi};
          shift_next = tx_reg;
          bits_next = 4'h0;
        end
      end else if (bits_reg == 4'h0 && wr_data) begin
        shift_next = sfr_req_in.wdata;
      end
    end
    if (done && !push_ready) begin
      ovr_next = 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      divider_reg <= spp_pkg::RST_SCK_DIVIDER;
      tx_reg <= spp_pkg::RST_TX_RX_DATA;
      shift_reg <= spp_pkg::RST_TX_RX_DATA;
      cnt_reg <= 8'h00;
      bits_reg <= 4'h0;
      sck_reg <= 1'b0;
      sck_prev_reg <= 1'b0;
      nss_prev_reg <= 1'b1;
      fault_reg <= 1'b0;
      ovr_reg <= 1'b0;
      rdata_reg <= 8'h00;
      state_reg <= spp_pkg::SPP_IDLE;
    end else begin
      divider_reg <= divider_next;
      tx_reg <= tx_next;
      shift_reg <= shift_next;
      cnt_reg <= cnt_next;
      bits_reg <= bits_next;
      sck_reg <= sck_next;
      sck_prev_reg <= sck_prev_next;
      nss_prev_reg <= nss_prev_next;
      fault_reg <= fault_next;
      ovr_reg <= ovr_next;
      rdata_reg <= rdata_next;
      state_reg <= state_next;
    end
  end

  // two-entry receive buffer
  assign push = done && push_ready;
  assign pop = rd_data && rx_valid_out;

  always_comb begin
    fifo_mem_next = fifo_mem_reg;
    wptr_next = wptr_reg;
    rptr_next = rptr_reg;
    count_next = count_reg;
    if (push) begin
      fifo_mem_next[wptr_reg] = done_byte;
      wptr_next = !wptr_reg;
    end
    if (pop) begin
      rptr_next = !rptr_reg;
    end
    if (push && !pop) begin
      count_next = count_reg + 2'h1;
    end else if (pop && !push) begin
      count_next = count_reg - 2'h1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < spp_pkg::FIFO_DEPTH; i++) begin
        fifo_mem_reg[i] <= 8'h00;
      end
      wptr_reg <= 1'b0;
      rptr_reg <= 1'b0;
      count_reg <= 2'h0;
    end else begin
      fifo_mem_reg <= fifo_mem_next;
      wptr_reg <= wptr_next;
      rptr_reg <= rptr_next;
      count_reg <= count_next;
    end
  end

  // pins
  always_comb begin
    pin_out.sck = sck_reg;
    pin_out.mosi = shift_reg[7];
    pin_out.miso = shift_reg[7];
    pin_out.slave_select_line = select_mode_field_in[spp_pkg::SEL_LEVEL_BIT];
    pin_oe_out.sck = master_fn;
    pin_oe_out.mosi = master_fn;
    pin_oe_out.miso = enable_in && !master_fn && selected;
    pin_oe_out.slave_select_line = enable_in && select_mode_field_in[spp_pkg::SEL_OUT_BIT];
  end

  assign select_pin_mapped_out = select_mode_field_in != spp_pkg::SEL_THREE_WIRE;
  assign sfr_rdata_out = rdata_reg;
  assign busy_out = state_reg == spp_pkg::SPP_SHIFT;
  assign rx_valid_out = count_reg != 2'h0;
  assign mode_fault_out = fault_reg;
  assign overrun_out = ovr_reg;

  // checking helpers
  logic [8:0] hold_reg, hold_next;
  logic [3:0] edge_reg, edge_next;

  always_comb begin
    hold_next = hold_reg + 9'h001;
    edge_next = edge_reg;
    // idle restarts the count so the first half period is measured too
    if (sck_next != sck_reg || state_reg == spp_pkg::SPP_IDLE) begin
      hold_next = 9'h000;
    end
    if (state_reg == spp_pkg::SPP_IDLE) begin
      edge_next = 4'h0;
    end else if (sck_next && !sck_reg) begin
      edge_next = edge_reg + 4'h1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hold_reg <= 9'h000;
      edge_reg <= 4'h0;
    end else begin
      hold_reg <= hold_next;
      edge_reg <= edge_next;
    end
  end

  a_sck_half_period: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (busy_out && master_fn && $changed(sck_reg) && $past(busy_out) && $past(sck_reg, 2) == $past(sck_reg))
    |-> $past(hold_reg) == {1'b0, $past(divider_reg)})
    else $error("sck half period differs from divider plus one");
  a_sck_idle_low: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (!busy_out && $past(!busy_out)) |-> !sck_reg)
    else $error("sck moved while no transfer active");
  a_eight_edges: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (done && master_fn) |-> edge_reg == spp_pkg::BITS_PER_XFER)
    else $error("master transfer did not have eight clock edges");
  a_write_starts: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (wr_data && master_fn && !busy_out && push_ready && !nss_fall) |=> busy_out && tx_reg == $past(sfr_req_in.wdata))
    else $error("data write did not start a master transfer");
  a_miso_release: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (!enable_in || (!master_fn && select_mode_field_in == spp_pkg::SEL_FOUR_SLAVE && pin_in.slave_select_line))
    |-> !pin_oe_out.miso)
    else $error("miso driven while port not selected");
  a_mosi_master: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    pin_oe_out.mosi |-> master_fn && !pin_oe_out.miso && pin_out.mosi == shift_reg[7])
    else $error("mosi direction or source wrong");
  a_fault_on_fall: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (master_fn && nss_fall && select_mode_field_in == spp_pkg::SEL_FOUR_SLAVE)
    |=> !pin_oe_out.sck && mode_fault_out)
    else $error("master function kept after select fell");
  a_nss_level: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (enable_in && select_mode_field_in[1]) |-> pin_oe_out.slave_select_line && pin_out.slave_select_line == select_mode_field_in[0])
    else $error("select output level wrong");
  a_read_rx: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (rd_data && rx_valid_out) |=> sfr_rdata_out == $past(fifo_mem_reg[rptr_reg]))
    else $error("data read did not return receive buffer");
  a_select_input: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (select_mode_field_in == spp_pkg::SEL_FOUR_SLAVE) |-> !pin_oe_out.slave_select_line)
    else $error("select line driven in mode 01");
  a_three_wire_pin: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (select_mode_field_in == spp_pkg::SEL_THREE_WIRE)
    |-> !select_pin_mapped_out && !pin_oe_out.slave_select_line)
    else $error("select line used in three-wire mode");
  a_slave_miso_drive: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (enable_in && !master_fn && select_mode_field_in == spp_pkg::SEL_THREE_WIRE)
    |-> pin_oe_out.miso && pin_out.miso == shift_reg[7])
    else $error("three-wire slave not driving miso from shift msb");
  a_slave_no_sck: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !master_fn |-> !pin_oe_out.sck && !pin_oe_out.mosi)
    else $error("sck or mosi driven without master function");
  a_unsel_ignore: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (enable_in && !master_fn && select_mode_field_in == spp_pkg::SEL_FOUR_SLAVE && pin_in.slave_select_line)
    |=> bits_reg == 4'h0)
    else $error("unselected slave counted sck edges");
  a_done_pushes: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (done && push_ready) |=> rx_valid_out)
    else $error("finished byte not placed in receive buffer");
  a_overrun_set: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (done && !push_ready) |=> overrun_out)
    else $error("lost byte did not raise overrun");
  a_fault_sticky: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (mode_fault_out && !clear_flags_in) |=> mode_fault_out)
    else $error("mode fault dropped without clear");
  a_empty_read: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (rd_data && !rx_valid_out) |=> sfr_rdata_out == spp_pkg::RDATA_EMPTY)
    else $error("empty receive buffer read returned data");
  a_divider_write: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (sfr_req_in.wr && is_addr(sfr_req_in, spp_pkg::ADDR_SCK_DIVIDER))
    |=> divider_reg == $past(sfr_req_in.wdata))
    else $error("divider write not taken");
endmodule // spp_port

// ---- common/spp_pkg.sv ----
// Purpose: shared constants and types of the serial peripheral port
// Assumes: byte-wide special-function register access
// Notes: all numbers of the block live here
package spp_pkg;
  localparam logic [7:0] ADDR_SCK_DIVIDER = 8'hA2;
  localparam logic [7:0] ADDR_TX_RX_DATA = 8'hA3;
  localparam logic [7:0] RST_SCK_DIVIDER = 8'h00;
  localparam logic [7:0] RST_TX_RX_DATA = 8'h00;
  localparam logic [1:0] SEL_THREE_WIRE = 2'h0;
  localparam logic [1:0] SEL_FOUR_SLAVE = 2'h1;
  localparam int SEL_OUT_BIT = 1;
  localparam int SEL_LEVEL_BIT = 0;
  localparam logic [3:0] BITS_PER_XFER = 4'h8;
  localparam logic [3:0] BITS_LAST = 4'h7;
  localparam int FIFO_DEPTH = 2;
  localparam logic [1:0] FIFO_FULL_CNT = 2'h2;
  localparam logic [7:0] RDATA_EMPTY = 8'h00;

  typedef enum logic {SPP_IDLE, SPP_SHIFT} spp_state_t;

  // one bit per serial line
  typedef struct packed {
    logic sck;
    logic mosi;
    logic miso;
    logic slave_select_line;
  } spp_pins_t;

  // one register access per cycle
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } spp_sfr_req_t;
endpackage

// ---- test/spp_slave_model.sv ----
// Purpose: far-side serial slave for master transfers of the port
// Assumes: mode 0 framing, sck idle low, sampled on rise
// Notes: deselected, miso shows the inverse of its last bit
`timescale 1ns/1ns
module spp_slave_model (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic sck_in,
  input wire logic mosi_in,
  input wire logic sel_n_in,
  input wire logic load_in,
  input wire logic [7:0] tx_in,
  output logic miso_out,
  output logic [7:0] rx_out
);
  logic [7:0] sh_reg;
  logic sck_d;
  logic mosi_lo;
  // sole slave on the bus, so no select in three-wire use
  assign miso_out = sel_n_in ? ~sh_reg[7] : sh_reg[7];
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sh_reg <= 8'h00;
      sck_d <= 1'b0;
      mosi_lo <= 1'b0;
      rx_out <= 8'h00;
    end else if (load_in) begin
      sh_reg <= tx_in;
    end else begin
      sck_d <= sck_in;
      if (!sck_in) mosi_lo <= mosi_in;
      if (sck_in && !sck_d) rx_out <= {rx_out[6:0], mosi_lo};
      // move miso on the clock edge that sees a rise, one cycle after sck rises, ahead of the next master sample
      if (sck_in && !sck_d) sh_reg <= {sh_reg[6:0], 1'b0};
    end
  end
endmodule // spp_slave_model

// ---- test/spp_port_tb.sv ----
// Purpose: self-checking bench of the serial peripheral port
// Assumes: mode 0 framing, slave model on the far side
// Notes: fixed seed; divider boundaries among random draws
`timescale 1ns/1ns
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin failures++; \
  $display("Error %0t: value mismatch", $time); end end
module spp_port_tb;
  logic clk, rst_n, en, mst, clr, tb_sck, tb_mosi, tb_nss, sl_load, sl_miso, sck_d;
  logic mapped, busy, rxv, fault, ovr;
  logic [1:0] md;
  logic [7:0] rdata, sl_tx, sl_rx, dv, b1, b2;
  spp_pkg::spp_sfr_req_t req;
  spp_pkg::spp_pins_t pin_i, pin_o, pin_oe;
  int failures, n_checks, cyc, n_hi, n_rise;
  assign pin_i = '{sck: tb_sck, mosi: tb_mosi, miso: sl_miso, slave_select_line: tb_nss};
  spp_port i_spp_port (.clk_in(clk), .rst_n_in(rst_n), .sfr_req_in(req),
    .sfr_rdata_out(rdata), .enable_in(en), .master_in(mst), .select_mode_field_in(md),
    .clear_flags_in(clr), .pin_in(pin_i), .pin_out(pin_o), .pin_oe_out(pin_oe),
    .select_pin_mapped_out(mapped), .busy_out(busy), .rx_valid_out(rxv),
    .mode_fault_out(fault), .overrun_out(ovr));
  spp_slave_model i_spp_slave_model (.clk_in(clk), .rst_n_in(rst_n), .sck_in(pin_o.sck),
    .mosi_in(pin_o.mosi), .sel_n_in(md[1] & pin_o.slave_select_line), .load_in(sl_load),
    .tx_in(sl_tx), .miso_out(sl_miso), .rx_out(sl_rx));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(negedge clk) begin
    if (busy && pin_o.sck) n_hi++;
    if (busy && pin_o.sck && !sck_d) n_rise++;
    sck_d = pin_o.sck;
    if (rst_n && en && mst && !busy) `CHK(pin_o.sck, 1'b0)
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      failures++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic sfr(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clk);
    req <= '0;
    #1;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    sfr(1'b0, a, 8'h00);
    `CHK(rdata, exp)
  endtask
  task automatic mxfer(input logic [1:0] m, input logic [7:0] d, input logic [7:0] tx,
                       input logic [7:0] sl, input logic rd);
    int t;
    t = 0;
    md <= m;
    sl_tx <= sl;
    sl_load <= 1'b1;
    sfr(1'b1, spp_pkg::ADDR_SCK_DIVIDER, d);
    sl_load <= 1'b0;
    n_hi = 0;
    n_rise = 0;
    sfr(1'b1, spp_pkg::ADDR_TX_RX_DATA, tx);
    `CHK(busy, 1'b1)
    `CHK({pin_oe.sck, pin_oe.mosi, pin_oe.miso}, 3'h6)
    while (busy !== 1'b0 && t < 5000) begin
      @(posedge clk);
      #1;
      t++;
    end
    `CHK(busy, 1'b0)
    `CHK(n_rise, 8)
    `CHK(n_hi, 8 * (d + 1))
    `CHK(sl_rx, tx)
    if (rd) rd_chk(spp_pkg::ADDR_TX_RX_DATA, sl);
  endtask
  task automatic frame(input logic [7:0] b, input logic [7:0] t);
    for (int i = 7; i >= 0; i--) begin
      @(posedge clk);
      tb_mosi <= b[i];
      if (pin_oe.miso) `CHK(pin_o.miso, t[i])
      repeat (2) @(posedge clk);
      tb_sck <= 1'b1;
      repeat (2) @(posedge clk);
      tb_sck <= 1'b0;
    end
    repeat (4) @(posedge clk);
    #1;
  endtask
  initial begin
    {rst_n, clr, tb_sck, tb_mosi, sl_load, md, sl_tx} = '0;
    {en, mst, tb_nss} = 3'h7;
    req = '0;
    void'($urandom(27941));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(spp_pkg::ADDR_SCK_DIVIDER, spp_pkg::RST_SCK_DIVIDER);
    rd_chk(spp_pkg::ADDR_TX_RX_DATA, spp_pkg::RDATA_EMPTY);
    rd_chk(8'h55, 8'h00);
    for (int m = 0; m < 4; m++) begin
      md <= 2'(m);
      @(posedge clk);
      #1;
      `CHK(mapped, m != 0)
      `CHK(pin_oe.slave_select_line, m[1])
      if (m > 1) `CHK(pin_o.slave_select_line, m[0])
    end
    for (int i = 0; i < 10; i++) begin
      dv = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom % 4);
      mxfer(2'(i % 3), dv, 8'($urandom), 8'($urandom), 1'b1);
    end
    b1 = 8'($urandom);
    b2 = 8'($urandom);
    mxfer(2'h0, 8'h01, 8'h81, b1, 1'b0);
    mxfer(2'h0, 8'h01, 8'h7E, b2, 1'b0);
    sfr(1'b1, spp_pkg::ADDR_TX_RX_DATA, 8'h11);
    `CHK(busy, 1'b0)
    rd_chk(spp_pkg::ADDR_TX_RX_DATA, b1);
    rd_chk(spp_pkg::ADDR_TX_RX_DATA, b2);
    md <= spp_pkg::SEL_FOUR_SLAVE;
    sfr(1'b1, spp_pkg::ADDR_TX_RX_DATA, 8'h3C);
    repeat (6) @(posedge clk);
    tb_nss <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    `CHK({fault, busy}, 2'h2)
    tb_nss <= 1'b1;
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    #1;
    `CHK(fault, 1'b0)
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    #1;
    `CHK(fault, 1'b0)
    mst <= 1'b0;
    md <= spp_pkg::SEL_THREE_WIRE;
    sfr(1'b1, spp_pkg::ADDR_TX_RX_DATA, 8'hA5);
    `CHK({pin_oe.sck, pin_oe.mosi, pin_oe.miso}, 3'h1)
    b1 = 8'($urandom);
    frame(b1, 8'hA5);
    `CHK(pin_o.miso, 1'b1)
    frame(8'h96, 8'hA5);
    frame(8'h69, 8'hA5);
    `CHK(ovr, 1'b1)
    rd_chk(spp_pkg::ADDR_TX_RX_DATA, b1);
    rd_chk(spp_pkg::ADDR_TX_RX_DATA, 8'h96);
    md <= spp_pkg::SEL_FOUR_SLAVE;
    frame(8'h5A, 8'hA5);
    `CHK({rxv, pin_oe.miso}, 2'h0)
    tb_nss <= 1'b0;
    frame(8'hC3, 8'hA5);
    `CHK(pin_oe.miso, 1'b1)
    rd_chk(spp_pkg::ADDR_TX_RX_DATA, 8'hC3);
    en <= 1'b0;
    @(posedge clk);
    #1;
    `CHK(pin_oe.miso, 1'b0)
    print_verdict();
  end
endmodule // spp_port_tb
